// ==== hw/fir_decim.v ====
// Decimating sum-of-products filter with coefficient and sample memories and filter-phase sync.
// Assumes comb-stage samples arrive as one-cycle strobes on clk_in and sync pins are external.
`timescale 1ns/1ns
`include "fir_decim_regs.vh"
module fir_decim
(
    // Clock and reset
    input wire clk_in,
    input wire rst_b_in,
    // APB slave
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [13:0] paddr_in,
    input wire [31:0] pwdata_in,
    output reg [31:0] prdata_out,
    output reg pready_out,
    output reg pslverr_out,
    // Comb-stage samples
    input wire samp_valid_in,
    input wire [17:0] samp_i_in,
    input wire [17:0] samp_q_in,
    input wire comb_sync_local_in,
    // Sync pins
    input wire comb_sync_pin_in,
    input wire fir_sync_pin_in,
    output reg comb_sync_pin_out,
    output reg fir_sync_pin_out,
    output reg sync_pin_oe_out,
    // Realignment pulses to comb stages
    output reg comb_realign_out,
    // Filter results
    output reg res_valid_out,
    output reg [23:0] res_i_out,
    output reg [23:0] res_q_out
);
    localparam ST_IDLE = 1'b0;
    localparam ST_MAC = 1'b1;

    reg [19:0] coef_mem [0:255];
    reg [35:0] data_mem [0:255];
    reg [7:0] mode_r;
    reg [3:0] out_ctrl_r;
    reg [7:0] ratio_r;
    reg [7:0] base_off_r;
    reg [7:0] taps_r;
    reg [7:0] wr_ptr_r;
    reg [7:0] phase_r;
    reg state_r;
    reg [7:0] tap_cnt_r;
    reg [7:0] rd_ptr_r;
    reg [7:0] coef_ptr_r;
    reg signed [40:0] acc_i_r;
    reg signed [40:0] acc_q_r;
    reg trig_nxt;
    wire [11:0] widx = paddr_in[13:2];
    wire master = mode_r[`MODE_SYNC_MASTER_BIT];
    wire apb_wr = psel_in & penable_in & pwrite_in;
    wire apb_wr_go = apb_wr & pready_out;
    // Read data is registered at the setup edge so that it stands through the access phase.
    wire apb_setup_rd = psel_in & ~penable_in & ~pwrite_in;

    function is_mapped;
        input [11:0] a;
        begin
            is_mapped = (a <= `DATA_LAST_ADDR) || (a == `MODE_IDX) || (a == `OUT_CTRL_IDX) ||
                (a == `RATIO_IDX) || (a == `BASE_OFF_IDX) || (a == `TAPS_IDX) || (a == `STATUS_IDX);
        end
    endfunction

    // Rounds a 16-bit result after scaling; saturation keeps a small shift from wrapping.
    function [15:0] round16;
        input signed [40:0] acc;
        input [2:0] shift;
        reg signed [40:0] res;
        reg signed [47:0] scaled;
        reg signed [47:0] rnd;
        begin
            res = acc >>> `PROD_LSB;
            scaled = {{7{res[40]}}, res} <<< (`OUT_WEIGHT_BASE - {2'b00, shift});
            rnd = (scaled + 48'sh40) >>> 7;
            if (rnd > 48'sh7FFF)
                round16 = 16'h7FFF;
            else if (rnd < -48'sh8000)
                round16 = 16'h8000;
            else
                round16 = rnd[15:0];
        end
    endfunction

    // Pin inputs pass three flops; a change counts once the last two agree.
    // An external pulse must therefore stand for two clocks at the pin before it is taken.
    wire [1:0] pin_raw = {fir_sync_pin_in, comb_sync_pin_in};
    wire [1:0] pin_rise;
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : pin_sync
            reg [2:0] sy_r;
            reg seen_r;
            assign pin_rise[g] = sy_r[1] & sy_r[2] & ~seen_r;
            always @(posedge clk_in or negedge rst_b_in)
            begin
                if (!rst_b_in)
                begin
                    sy_r <= 3'h0;
                    seen_r <= 1'b0;
                end
                else
                begin
                    sy_r <= {sy_r[1:0], pin_raw[g]};
                    if (sy_r[1] == sy_r[2])
                        seen_r <= sy_r[2];
                end
            end
        end
    endgenerate
    wire comb_pin_rise = pin_rise[0];
    wire fir_pin_rise = pin_rise[1];

    // Registers over APB; zero wait states.
    always @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            mode_r <= `MODE_RESET;
            out_ctrl_r <= 4'h0;
            ratio_r <= `ZERO8;
            base_off_r <= `ZERO8;
            taps_r <= `ZERO8;
            prdata_out <= 32'h00000000;
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
        end
        else
        begin
            pready_out <= psel_in & ~penable_in;
            pslverr_out <= psel_in & ~penable_in & ~is_mapped(widx);
            if (apb_wr_go)
            begin
                case (widx)
                    `MODE_IDX: mode_r <= pwdata_in[7:0];
                    `OUT_CTRL_IDX: out_ctrl_r <= pwdata_in[3:0];
                    `RATIO_IDX: ratio_r <= (pwdata_in[7:0] > `RATIO_MAX) ? `RATIO_MAX : pwdata_in[7:0];
                    `BASE_OFF_IDX: base_off_r <= pwdata_in[7:0];
                    `TAPS_IDX: taps_r <= pwdata_in[7:0];
                    default: ;
                endcase
            end
            if (apb_setup_rd)
            begin
                prdata_out <= 32'h00000000;
                if (widx <= `COEF_LAST_ADDR)
                    prdata_out <= {12'h000, coef_mem[widx[7:0]]};
                else if (widx <= `DATA_LAST_ADDR)
                    prdata_out <= {28'h0000000, data_mem[widx[7:0]][35:32]};
                else
                    case (widx)
                        `MODE_IDX: prdata_out <= {24'h000000, mode_r};
                        `OUT_CTRL_IDX: prdata_out <= {28'h0000000, out_ctrl_r};
                        `RATIO_IDX: prdata_out <= {24'h000000, ratio_r};
                        `BASE_OFF_IDX: prdata_out <= {24'h000000, base_off_r};
                        `TAPS_IDX: prdata_out <= {24'h000000, taps_r};
                        `STATUS_IDX: prdata_out <= {15'h0000, state_r, wr_ptr_r, phase_r};
                        default: prdata_out <= 32'h00000000;
                    endcase
            end
        end
    end

    // Coefficient memory writes; software owns it entirely.
    always @(posedge clk_in)
    begin
        if (apb_wr_go && widx <= `COEF_LAST_ADDR)
            coef_mem[widx[7:0]] <= pwdata_in[19:0];
    end

    // Sample memory: circular write, software may clear the used region.
    always @(posedge clk_in)
    begin
        if (samp_valid_in)
            data_mem[wr_ptr_r] <= {samp_q_in, samp_i_in};
        else if (apb_wr_go && widx >= `DATA_BASE_ADDR && widx <= `DATA_LAST_ADDR)
            data_mem[widx[7:0]] <= {pwdata_in[3:0], 32'h00000000};
    end

    // Decimation phase: master runs on its own comb strobes, slave realigns on pins.
    wire comb_evt = master ? comb_sync_local_in : comb_pin_rise;
    // A master keeps its own phase; its read-back filter pulse would otherwise retrigger it.
    wire fir_evt = ~master & fir_pin_rise;
    always @*
    begin
        trig_nxt = 1'b0;
        if (samp_valid_in && (fir_evt || phase_r >= ratio_r))
            trig_nxt = 1'b1;
    end

    always @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            wr_ptr_r <= `ZERO8;
            phase_r <= `ZERO8;
            comb_sync_pin_out <= 1'b0;
            fir_sync_pin_out <= 1'b0;
            sync_pin_oe_out <= 1'b0;
            comb_realign_out <= 1'b0;
        end
        else
        begin
            sync_pin_oe_out <= master;
            // A master answers the pulse that stands on its own pad, which the pin filter would drop.
            comb_realign_out <= master ? comb_sync_pin_out : comb_pin_rise;
            comb_sync_pin_out <= comb_evt & samp_valid_in;
            fir_sync_pin_out <= trig_nxt & comb_evt;
            if (samp_valid_in)
            begin
                wr_ptr_r <= wr_ptr_r + `ONE8;
                if (fir_evt)
                    phase_r <= `ONE8;
                else
                    phase_r <= trig_nxt ? `ZERO8 : phase_r + `ONE8;
            end
        end
    end

    // Multiply-accumulate: newest sample lives at wr_ptr-1, oldest used sample is taps back.
    wire signed [17:0] si = data_mem[rd_ptr_r][17:0];
    wire signed [17:0] sq = data_mem[rd_ptr_r][35:18];
    wire signed [19:0] cw = coef_mem[coef_ptr_r];
    wire wide_mode = out_ctrl_r[`OUT_WIDE_BIT];
    wire [2:0] oshift = out_ctrl_r[`OUT_SHIFT_MSB:`OUT_SHIFT_LSB];
    wire signed [40:0] sum_i = acc_i_r + si * cw;
    wire signed [40:0] sum_q = acc_q_r + sq * cw;
    wire signed [40:0] full_i = sum_i >>> `PROD_LSB;
    wire signed [40:0] full_q = sum_q >>> `PROD_LSB;
    wire [23:0] wide_i = {full_i[`RESULT_W-1:0], 1'b0};
    wire [23:0] wide_q = {full_q[`RESULT_W-1:0], 1'b0};

    always @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            state_r <= ST_IDLE;
            tap_cnt_r <= `ZERO8;
            rd_ptr_r <= `ZERO8;
            coef_ptr_r <= `ZERO8;
            acc_i_r <= 41'sh0;
            acc_q_r <= 41'sh0;
            res_valid_out <= 1'b0;
            res_i_out <= 24'h000000;
            res_q_out <= 24'h000000;
        end
        else
        begin
            res_valid_out <= 1'b0;
            case (state_r)
                ST_IDLE:
                begin
                    if (trig_nxt)
                    begin
                        state_r <= ST_MAC;
                        tap_cnt_r <= taps_r;
                        rd_ptr_r <= wr_ptr_r - taps_r;
                        coef_ptr_r <= base_off_r;
                        acc_i_r <= 41'sh0;
                        acc_q_r <= 41'sh0;
                    end
                end
                ST_MAC:
                begin
                    acc_i_r <= acc_i_r + si * cw;
                    acc_q_r <= acc_q_r + sq * cw;
                    rd_ptr_r <= rd_ptr_r + `ONE8;
                    coef_ptr_r <= coef_ptr_r + `ONE8;
                    tap_cnt_r <= tap_cnt_r - `ONE8;
                    if (tap_cnt_r == `ZERO8)
                    begin
                        state_r <= ST_IDLE;
                        res_valid_out <= 1'b1;
                        if (wide_mode)
                        begin
                            res_i_out <= wide_i;
                            res_q_out <= wide_q;
                        end
                        else
                        begin
                            res_i_out <= {round16(sum_i, oshift), 8'h00};
                            res_q_out <= {round16(sum_q, oshift), 8'h00};
                        end
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end
endmodule

// ==== hw/fir_decim_regs.vh ====
// Register map, field positions and constants of the decimating sum-of-products filter.
// Assumes an APB master with 32-bit data; each register takes one aligned word.
`ifndef FIR_DECIM_REGS_VH
`define FIR_DECIM_REGS_VH
`define COEF_BASE_ADDR 12'h000
`define COEF_LAST_ADDR 12'h0FF
`define DATA_BASE_ADDR 12'h100
`define DATA_LAST_ADDR 12'h1FF
`define MODE_IDX 12'h300
`define OUT_CTRL_IDX 12'h309
`define RATIO_IDX 12'h30A
`define BASE_OFF_IDX 12'h30B
`define TAPS_IDX 12'h30C
`define STATUS_IDX 12'h3F0
`define MODE_SYNC_MASTER_BIT 3
`define MODE_DIVERSITY_BIT 1
`define MODE_RESET 8'h00
`define OUT_SHIFT_LSB 0
`define OUT_SHIFT_MSB 2
`define OUT_WIDE_BIT 3
`define OUT_WEIGHT_BASE 5'h07
`define SAMPLE_W 18
`define COEF_W 20
`define ACC_W 41
`define RESULT_W 23
`define PORT_W 16
`define WIDE_W 24
`define PROD_LSB 15
`define ONE8 8'h01
`define ZERO8 8'h00
`define RATIO_MAX 8'h1F
`endif

// ==== tb/comb_stage_model.sv ====
// Upstream comb stage: one sample every gap_in+1 cycles while run_in is high.
// Assumes one clock; data lines show garbage between strobes.
`timescale 1ns/1ns
module comb_stage_model
(
    input wire clk_in,
    input wire rst_b_in,
    input wire run_in,
    input wire [3:0] gap_in,
    output reg samp_valid_out,
    output reg [17:0] samp_i_out,
    output reg [17:0] samp_q_out,
    output reg comb_sync_out
);
reg [3:0] wait_r;
reg [17:0] n_r;
always @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
        wait_r <= 4'h0;
        n_r <= 18'h00000;
        samp_valid_out <= 1'b0;
        comb_sync_out <= 1'b0;
        samp_i_out <= 18'h00000;
        samp_q_out <= 18'h00000;
    end
    else if (run_in && wait_r == 4'h0)
    begin
        wait_r <= gap_in;
        n_r <= n_r + 18'h00001;
        samp_valid_out <= 1'b1;
        comb_sync_out <= 1'b1;
        samp_i_out <= n_r + 18'h00001;
        samp_q_out <= 18'h00000 - n_r - 18'h00001;
    end
    else
    begin
        wait_r <= (wait_r == 4'h0) ? 4'h0 : wait_r - 4'h1;
        samp_valid_out <= 1'b0;
        comb_sync_out <= 1'b0;
        samp_i_out <= ~samp_i_out;
        samp_q_out <= ~samp_q_out;
    end
endmodule

// ==== tb/fir_decim_props.sv ====
// Port checker for the decimating filter.
// Assumes it is bound to fir_decim from the bench top.
`timescale 1ns/1ns
module fir_decim_props
(
    input wire clk_in,
    input wire rst_b_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire pready_out,
    input wire pslverr_out,
    input wire samp_valid_in,
    input wire comb_sync_local_in,
    input wire comb_sync_pin_in,
    input wire comb_sync_pin_out,
    input wire fir_sync_pin_out,
    input wire sync_pin_oe_out,
    input wire comb_realign_out,
    input wire res_valid_out
);
default clocking @(posedge clk_in); endclocking
default disable iff (!rst_b_in);
// Saturating count of cycles since the last sample bounds the result latency.
reg [8:0] idle_r;
always @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
        idle_r <= 9'h000;
    else if (samp_valid_in)
        idle_r <= 9'h000;
    else if (idle_r != 9'h1FF)
        idle_r <= idle_r + 9'h001;
ready_after_setup_a: assert property (psel_in && !penable_in |=> pready_out)
    else $error("no ready after setup");
error_in_access_a: assert property (pslverr_out |-> pready_out && psel_in && penable_in)
    else $error("error outside access");
fir_with_comb_a: assert property (fir_sync_pin_out |-> comb_sync_pin_out)
    else $error("filter sync without comb sync");
master_drives_a: assert property (sync_pin_oe_out && comb_sync_local_in |-> ##[1:3] comb_sync_pin_out)
    else $error("master did not drive comb sync");
pin_realigns_a: assert property ($rose(comb_sync_pin_in) |-> ##[1:6] comb_realign_out)
    else $error("comb sync edge not taken");
result_pulse_a: assert property (res_valid_out |=> !res_valid_out)
    else $error("result strobe too long");
result_latency_a: assert property (res_valid_out |-> idle_r <= 9'h102)
    else $error("result too late after sample");
oe_by_write_a: assert property ($changed(sync_pin_oe_out) |-> $past(psel_in && penable_in && pwrite_in)
    || $past(psel_in && penable_in && pwrite_in, 2)) else $error("sync drive changed without write");
endmodule

// ==== tb/tb_top.sv ====
// Bench for fir_decim: APB register tests, filter sums, decimation rate and sync pins.
// Assumes the comb stage model and the port checker are compiled first.
`timescale 1ns/1ns
module tb_top;
reg clk_in = 1'b0;
reg rst_b_in = 1'b0;
reg psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, ext_comb = 1'b0, run = 1'b0;
reg [13:0] paddr_in = 14'h0000;
reg [31:0] pwdata_in = 32'h00000000;
reg [3:0] gap = 4'h7;
wire [31:0] prdata_out;
wire pready_out, pslverr_out, samp_valid_in, comb_sync_local_in, comb_sync_pin_out;
wire fir_sync_pin_out, sync_pin_oe_out, comb_realign_out, res_valid_out;
wire [17:0] samp_i_in, samp_q_in;
wire [23:0] res_i_out, res_q_out;
// Pins resolve between the device driver and the external peer.
wire comb_pin = sync_pin_oe_out ? comb_sync_pin_out : ext_comb;
wire fir_pin = sync_pin_oe_out ? fir_sync_pin_out : 1'b0;
integer errors = 0, compares = 0, nval = 0, nres = 0, ncomb = 0, nfir = 0, nre = 0;
integer last = 0, e, f, k, r;
integer kk[0:2];
reg mac_on = 1'b0;
reg nar = 1'b0;
reg [31:0] x;
reg err;
reg [31:0] rd;
always #25 clk_in = ~clk_in;
fir_decim u_fir_decim (.clk_in, .rst_b_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out, .samp_valid_in, .samp_i_in, .samp_q_in, .comb_sync_local_in,
    .comb_sync_pin_in(comb_pin), .fir_sync_pin_in(fir_pin), .comb_sync_pin_out, .fir_sync_pin_out,
    .sync_pin_oe_out, .comb_realign_out, .res_valid_out, .res_i_out, .res_q_out);
comb_stage_model u_comb_stage_model (.clk_in, .rst_b_in, .run_in(run), .gap_in(gap),
    .samp_valid_out(samp_valid_in), .samp_i_out(samp_i_in), .samp_q_out(samp_q_in),
    .comb_sync_out(comb_sync_local_in));
task check(input string nm, input [31:0] seen, input [31:0] exp);
begin
    compares = compares + 1;
    if (seen !== exp)
    begin
        errors = errors + 1;
        $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
end
endtask
task apb(input w, input [11:0] i, input [31:0] d);
    integer t;
begin
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= {i, 2'b00};
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    t = 0;
    @(posedge clk_in);
    while (pready_out !== 1'b1 && t < 20)
    begin
        @(posedge clk_in);
        t = t + 1;
    end
    errors = errors + (t == 20);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
end
endtask
task window(input integer n);
begin
    nval = 0;
    nres = 0;
    ncomb = 0;
    nfir = 0;
    nre = 0;
    // Run stays up just past the n-th strobe, so exactly n samples are sent.
    run <= 1'b1;
    repeat ((n - 1) * (gap + 1) + 2) @(posedge clk_in);
    run <= 1'b0;
    repeat (10) @(posedge clk_in);
    check("samples", 32'(nval), 32'(n));
end
endtask
task conclude;
begin
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
        $display("Simulation passed");
    else
        $display("Simulation failed");
    $finish;
end
endtask
always @(posedge clk_in)
begin
    nval = nval + samp_valid_in;
    ncomb = ncomb + comb_sync_pin_out;
    nfir = nfir + fir_sync_pin_out;
    nre = nre + comb_realign_out;
    if (samp_valid_in)
        last = $signed(samp_i_in);
    if (res_valid_out)
    begin
        nres = nres + 1;
        e = kk[0] * (last - 2) + kk[1] * (last - 1) + kk[2] * last;
        if (mac_on && last >= 3)
        begin
            x = nar ? (32'(e) << 8) : 32'(e * 2);
            check("res_i", {8'h00, res_i_out}, x & 32'h00FFFFFF);
            x = nar ? (32'(-e) << 8) : 32'(-e * 2);
            check("res_q", {8'h00, res_q_out}, x & 32'h00FFFFFF);
        end
    end
end
initial
begin
    repeat (3) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    apb(1'b0, 12'h300, 32'h00000000);
    check("mode", rd, 32'h00000000);
    check("oe", sync_pin_oe_out, 32'h00000000);
    apb(1'b1, 12'h30A, 32'h000000FF);
    apb(1'b0, 12'h30A, 32'h00000000);
    check("ratio", rd, 32'h0000001F);
    apb(1'b1, 12'h0FF, 32'hFFF7FFFF);
    apb(1'b0, 12'h0FF, 32'h00000000);
    check("coef", rd, 32'h0007FFFF);
    apb(1'b0, 12'h200, 32'h00000000);
    check("unmapped", err, 32'h00000001);
    for (k = 0; k < 4; k = k + 1)
        apb(1'b1, 12'(256 + k), 32'h00000000);
    apb(1'b1, 12'h30C, 32'h00000002);
    $display("test registers done");
    mac_on = 1'b1;
    for (f = 0; f < 2; f = f + 1)
    begin
        kk[0] = f ? 5 : 1;
        kk[1] = f ? 0 : 2;
        kk[2] = f ? -1 : 3;
        for (k = 0; k < 3; k = k + 1)
            apb(1'b1, 12'(4 + 4 * f + k), 32'(kk[k] * 32768));
        apb(1'b1, 12'h30B, 32'(4 + 4 * f));
        apb(1'b1, 12'h309, 32'(8 + 5 * f));
        for (r = 0; r < 4; r = r + r + 1)
        begin
            apb(1'b1, 12'h30A, 32'(r));
            window(12);
            check("rate", 32'(nres), 32'(12 / (r + 1)));
        end
        $display("test filter %0d done", f);
    end
    nar = 1'b1;
    apb(1'b1, 12'h309, 32'h00000000);
    window(12);
    $display("test narrow done");
    nar = 1'b0;
    mac_on = 1'b0;
    gap <= 4'h1;
    apb(1'b1, 12'h300, 32'h00000008);
    @(posedge clk_in);
    check("oe", sync_pin_oe_out, 32'h00000001);
    window(12);
    check("comb pulses", 32'(ncomb), 32'd12);
    check("fir pulses", 32'(nfir), 32'd3);
    check("own realign", 32'(nre), 32'd12);
    apb(1'b1, 12'h300, 32'h00000000);
    @(posedge clk_in);
    check("oe", sync_pin_oe_out, 32'h00000000);
    nre = 0;
    ext_comb <= 1'b1;
    repeat (2) @(posedge clk_in);
    ext_comb <= 1'b0;
    repeat (8) @(posedge clk_in);
    check("realign", 32'(nre), 32'd1);
    $display("test sync done");
    conclude;
end
initial
begin
    #500000;
    errors = errors + 1;
    conclude;
end
endmodule
bind fir_decim fir_decim_props u_fir_decim_props (.clk_in, .rst_b_in, .psel_in, .penable_in, .pwrite_in,
    .pready_out, .pslverr_out, .samp_valid_in, .comb_sync_local_in, .comb_sync_pin_in, .comb_sync_pin_out,
    .fir_sync_pin_out, .sync_pin_oe_out, .comb_realign_out, .res_valid_out);
